// ---- debug_wire_if.sv ----
// link between the pin multiplexer and the debug wire bit engine
`timescale 1ns/10ps
interface debug_wire_if;
  logic pinIn;    // sampled level of the debug pin
  logic enable;   // debug function owns the pin
  logic txStart;  // start one transmitted bit
  logic txBit;    // value of that bit
  logic drvOe;    // engine drives the pin
  logic drvOut;   // level driven
  logic busy;     // bit in progress
  logic rxValid;  // received bit pulse
  logic rxBit;    // received bit value
  modport phy (input pinIn, enable, txStart, txBit,
               output drvOe, drvOut, busy, rxValid, rxBit);
  modport mux (output pinIn, enable, txStart, txBit,
               input drvOe, drvOut, busy, rxValid, rxBit);
endinterface

// ---- debug_wire_phy.sv ----
// single-wire debug bit engine: pseudo open-drain with speedup pulses
`timescale 1ns/10ps
module debug_wire_phy
  import pin_mux_pkg::*;
#(
  parameter int BIT_CYCLES = DBG_BIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  debug_wire_if.phy dw
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  phy_state_t state;         // idle, receiving or sending
  logic [4:0] cnt;           // cycle within the bit
  logic       txVal;         // bit being sent
  logic       pinQ;          // previous pin level, edge detect
  logic [4:0] cntNext;       // incremented count
  logic [4:0] lowLen;        // low phase length of current bit
  logic       fallEdge;      // host pulled the line low
  logic       lastCycle;     // final cycle of a bit time

  assign cntNext   = cnt + 5'h01;
  assign lowLen    = txVal ? 5'(DBG_LOW_ONE) : 5'(DBG_LOW_ZERO);
  assign fallEdge  = pinQ & ~dw.pinIn;
  assign lastCycle = (cnt == 5'(BIT_CYCLES - 1));

  // ------------------------------------------------------------
  // bit sequencer
  // ------------------------------------------------------------
  // the line is only pulled low or pulsed high briefly, never held high,
  // so a host driving low at the same time cannot fight a strong high
  always_ff @(posedge clk) begin
    if (rst || !dw.enable) begin
      state      <= PHY_IDLE;
      cnt        <= 5'h00;
      txVal      <= 1'b0;
      pinQ       <= 1'b1;
      dw.drvOe   <= 1'b0;
      dw.drvOut  <= 1'b0;
      dw.busy    <= 1'b0;
      dw.rxValid <= 1'b0;
      dw.rxBit   <= 1'b0;
    end else begin
      pinQ       <= dw.pinIn;
      dw.rxValid <= 1'b0;
      case (state)
        PHY_IDLE: begin
          cnt <= 5'h00;
          if (dw.txStart) begin              // our own bit first
            state     <= PHY_TX;
            txVal     <= dw.txBit;
            dw.busy   <= 1'b1;
            dw.drvOe  <= 1'b1;
            dw.drvOut <= 1'b0;
          end else if (fallEdge) begin       // host started a bit
            state   <= PHY_RX;
            cnt     <= 5'h01;
            dw.busy <= 1'b1;
          end
        end
        PHY_TX: begin
          cnt       <= cntNext;
          // low phase, then one driven-high speedup, then released
          dw.drvOe  <= (cntNext < lowLen + 5'(DBG_SPEEDUP));
          dw.drvOut <= (cntNext >= lowLen);
          if (lastCycle) begin
            state    <= PHY_IDLE;
            dw.busy  <= 1'b0;
            dw.drvOe <= 1'b0;
          end
        end
        PHY_RX: begin
          cnt <= cntNext;
          if (cnt == 5'(DBG_SAMPLE_AT)) begin
            dw.rxValid <= 1'b1;
            dw.rxBit   <= dw.pinIn;
          end
          if (lastCycle) begin
            state   <= PHY_IDLE;
            dw.busy <= 1'b0;
          end
        end
        default: begin
          state <= PHY_IDLE;
        end
      endcase
    end
  end

endmodule // debug_wire_phy

// ---- pad_partner.sv ----
// board and debug host model resolving the pad levels
`timescale 1ns/10ps
module pad_partner #(parameter int N = 26) (
  input  wire logic         clk,
  input  wire logic [N-1:0] pinOut,
  input  wire logic [N-1:0] pinOe,
  input  wire logic [N-1:0] pinPullup,
  input  wire logic [N-1:0] extEn,   // board or host drives the pin
  input  wire logic [N-1:0] extVal,  // level it drives
  output logic      [N-1:0] pinIn
);
  logic tog = 1'b0;  // floating pins wander so no stale level passes
  always @(posedge clk) tog <= ~tog;
  // open drain: device drive wins, then host, then pullup
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : extEn[i] ? extVal[i] : pinPullup[i] ? 1'b1 : tog ^ i[0];
    end
  end
endmodule // pad_partner

// ---- pin_function_mux.sv ----
// pin function multiplexer with reset defaults and Avalon-MM registers
//
// How it works
// - shared reset pin starts as port input
// - sticky reset-pin enable until next reset
// - low on enabled reset pin requests reset
// - reset-pin enable forces its pullup on
// - debug pin samples mode during reset
// - debug-pin enable set by reset; software clears
// - mode pin high at release means normal
// - debug bit lasts sixteen debug clocks
// - debug pin open-drain with driven speedup pulses
// - segment pins reset to tristate port function
// - after reset all pins tristate, no pullup except on the debug pin
// - outputs get drive strength choice, and slew choice except on the debug pin in debug use
// - inputs get software pullup choice
// - highest enabled function owns the pin
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module pin_function_mux
  import pin_mux_pkg::*;
#(
  parameter int N = NUM_PINS
) (
  input  wire logic              clk,
  input  wire logic              rst,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // pads
  input  wire logic [N-1:0]      pinIn,
  output logic      [N-1:0]      pinOut,
  output logic      [N-1:0]      pinOe,
  output logic      [N-1:0]      pinPullup,
  output logic      [N-1:0]      pinDriveHigh,
  output logic      [N-1:0]      pinSlew,
  // peripheral side of each alternate function
  input  wire logic [N-1:0]      alt1Oe,
  input  wire logic [N-1:0]      alt1Out,
  input  wire logic [N-1:0]      alt2Oe,
  input  wire logic [N-1:0]      alt2Out,
  input  wire logic [N-1:0]      alt3Oe,
  input  wire logic [N-1:0]      alt3Out,
  output logic      [N-1:0]      portIn,
  output logic      [N-1:0]      alt1In,
  output logic      [N-1:0]      alt2In,
  output logic      [N-1:0]      alt3In,
  // background_debug_controller side
  input  wire logic              dbgTxStart,
  input  wire logic              dbgTxBit,
  output logic                   dbgBusy,
  output logic                   dbgRxValid,
  output logic                   dbgRxBit,
  // system
  output logic                   resetRequest,
  output logic                   activeBackgroundMode
);

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  logic [N-1:0] portOutReg;      // port output data
  logic [N-1:0] portDir;         // port direction
  logic [N-1:0] pullupEn;        // pullup choice for inputs
  logic [N-1:0] driveHigh;       // drive strength choice
  logic [N-1:0] slewEn;          // slew control choice
  logic [N-1:0] alt1En;          // first alternate enables
  logic [N-1:0] alt2En;          // second alternate enables
  logic [N-1:0] alt3En;          // third alternate enables
  logic         reset_pin_enable; // shared pin acts as reset
  logic         debug_pin_enable; // shared pin acts as debug wire
  logic [N-1:0] pinState;        // sampled pin levels
  logic         modeSample;      // mode_select_pin level during reset
  logic         rstQ;            // reset one cycle ago

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic        busReq;           // read or write pending
  logic        wrFire;           // write commits this edge
  logic [31:0] byteMask;         // lanes selected by byteenable
  logic [31:0] rdMux;            // read data selection
  logic        hitPortOut;
  logic        hitPortDir;
  logic        hitPullup;
  logic        hitDrive;
  logic        hitSlew;
  logic        hitAlt1;
  logic        hitAlt2;
  logic        hitAlt3;
  logic        hitSysOpt;
  logic [31:0] statusWord;       // status register image
  logic [31:0] sysOptWord;       // system_option_reg image

  assign busReq   = read | write;
  assign wrFire   = write & ~waitrequest;
  assign byteMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};

  assign hitPortOut = wrFire & (address == OFF_PORT_OUT);
  assign hitPortDir = wrFire & (address == OFF_PORT_DIR);
  assign hitPullup  = wrFire & (address == OFF_PULLUP);
  assign hitDrive   = wrFire & (address == OFF_DRIVE);
  assign hitSlew    = wrFire & (address == OFF_SLEW);
  assign hitAlt1    = wrFire & (address == OFF_ALT1_EN);
  assign hitAlt2    = wrFire & (address == OFF_ALT2_EN);
  assign hitAlt3    = wrFire & (address == OFF_ALT3_EN);
  assign hitSysOpt  = wrFire & (address == OFF_SYS_OPT);

  // merge a write into an old value honouring byte lanes
  function automatic logic [N-1:0] merge(input logic [N-1:0] old);
    logic [31:0] wide;
    wide = 32'(old);
    wide = (wide & ~byteMask) | (writedata & byteMask);
    return wide[N-1:0];
  endfunction

  assign sysOptWord = 32'({debug_pin_enable, reset_pin_enable});
  assign statusWord = 32'({dbgBusy, resetRequest, activeBackgroundMode});

  // unmapped offsets read as zero
  always_comb begin
    case (address)
      OFF_PORT_OUT:  rdMux = 32'(portOutReg);
      OFF_PORT_DIR:  rdMux = 32'(portDir);
      OFF_PULLUP:    rdMux = 32'(pullupEn);
      OFF_DRIVE:     rdMux = 32'(driveHigh);
      OFF_SLEW:      rdMux = 32'(slewEn);
      OFF_ALT1_EN:   rdMux = 32'(alt1En);
      OFF_ALT2_EN:   rdMux = 32'(alt2En);
      OFF_ALT3_EN:   rdMux = 32'(alt3En);
      OFF_SYS_OPT:   rdMux = sysOptWord;
      OFF_PIN_STATE: rdMux = 32'(pinState);
      OFF_STATUS:    rdMux = statusWord;
      default:       rdMux = REG_RESET;
    endcase
  end

  // ------------------------------------------------------------
  // bus handshake: one wait cycle, then the answer
  // ------------------------------------------------------------
  // waitrequest idles high so every request sees exactly one stall
  always_ff @(posedge clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata    <= REG_RESET;
    end else if (busReq && waitrequest) begin
      waitrequest <= 1'b0;
      readdata    <= read ? rdMux : REG_RESET;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // pin configuration registers
  // ------------------------------------------------------------
  // every pin but the debug pin (owned by the debug wire) comes out of reset as a plain input
  always_ff @(posedge clk) begin
    if (rst) begin
      portOutReg <= N'(REG_RESET);
      portDir    <= N'(REG_RESET);
      pullupEn   <= N'(REG_RESET);
      driveHigh  <= N'(REG_RESET);
      slewEn     <= N'(REG_RESET);
      alt1En     <= N'(REG_RESET);
      alt2En     <= N'(REG_RESET);
      alt3En     <= N'(REG_RESET);
    end else begin
      if (hitPortOut) portOutReg <= merge(portOutReg);
      if (hitPortDir) portDir    <= merge(portDir);
      if (hitPullup)  pullupEn   <= merge(pullupEn);
      if (hitDrive)   driveHigh  <= merge(driveHigh);
      if (hitSlew)    slewEn     <= merge(slewEn);
      if (hitAlt1)    alt1En     <= merge(alt1En);
      if (hitAlt2)    alt2En     <= merge(alt2En);
      if (hitAlt3)    alt3En     <= merge(alt3En);
    end
  end

  // ------------------------------------------------------------
  // system options
  // ------------------------------------------------------------
  // the reset-pin enable can only be set; only a reset clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_pin_enable <= RESET_PIN_RESET;
      debug_pin_enable <= DEBUG_PIN_RESET;
    end else if (hitSysOpt && byteenable[0]) begin
      reset_pin_enable <= reset_pin_enable
                        | writedata[SYSOPT_RESET_PIN_BIT];
      debug_pin_enable <= writedata[SYSOPT_DEBUG_PIN_BIT];
    end
  end

  // ------------------------------------------------------------
  // mode select at the release of reset
  // ------------------------------------------------------------
  // sampled without reset so the level held across the release is kept
  always_ff @(posedge clk) begin
    rstQ <= rst;
    if (rst) begin
      modeSample <= pinIn[DEBUG_PIN_IDX];
    end
  end

  // low at the release forces background mode, high runs normally
  always_ff @(posedge clk) begin
    if (rst) begin
      activeBackgroundMode <= 1'b0;
    end else if (rstQ) begin
      activeBackgroundMode <= ~modeSample;
    end
  end

  // ------------------------------------------------------------
  // external reset request
  // ------------------------------------------------------------
  // the system reset controller turns this into rst, which in turn
  // clears the enable and hands the pin back to the port
  always_ff @(posedge clk) begin
    if (rst) begin
      resetRequest <= 1'b0;
    end else begin
      resetRequest <= reset_pin_enable & ~pinIn[RESET_PIN_IDX];
    end
  end

  // ------------------------------------------------------------
  // debug wire engine
  // ------------------------------------------------------------
  debug_wire_if dw ();

  assign dw.pinIn   = pinIn[DEBUG_PIN_IDX];
  assign dw.enable  = debug_pin_enable;
  assign dw.txStart = dbgTxStart;
  assign dw.txBit   = dbgTxBit;

  debug_wire_phy #(
    .BIT_CYCLES (DBG_BIT_CYCLES)
  ) u_phy (
    .clk (clk),
    .rst (rst),
    .dw  (dw.phy)
  );

  // engine results to the controller, one flop later
  always_ff @(posedge clk) begin
    if (rst) begin
      dbgBusy    <= 1'b0;
      dbgRxValid <= 1'b0;
      dbgRxBit   <= 1'b0;
    end else begin
      dbgBusy    <= dw.busy;
      dbgRxValid <= dw.rxValid;
      dbgRxBit   <= dw.rxBit;
    end
  end

  // ------------------------------------------------------------
  // per-pin ownership and pad controls
  // ------------------------------------------------------------
  logic [N-1:0] en2;             // effective second alternate
  logic [N-1:0] oe2;             // second alternate output enable
  logic [N-1:0] out2;            // second alternate output data
  logic [N-1:0] dirEff;          // port direction, input-only masked
  logic [N-1:0] own1;            // first alternate owns the pin
  logic [N-1:0] own2;            // second alternate owns the pin
  logic [N-1:0] own3;            // third alternate owns the pin
  logic [N-1:0] ownPort;         // port owns the pin
  logic [N-1:0] next_oe;
  logic [N-1:0] next_out;
  logic [N-1:0] next_pull;
  logic [N-1:0] next_drive;
  logic [N-1:0] next_slew;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      if (i == RESET_PIN_IDX) begin : g_rst
        // the reset function only listens
        assign en2[i]    = reset_pin_enable;
        assign oe2[i]    = 1'b0;
        assign out2[i]   = 1'b0;
        assign dirEff[i] = 1'b0;
      end else if (i == DEBUG_PIN_IDX) begin : g_dbg
        assign en2[i]    = debug_pin_enable;
        assign oe2[i]    = dw.drvOe;
        assign out2[i]   = dw.drvOut;
        assign dirEff[i] = portDir[i];
      end else begin : g_gen
        assign en2[i]    = alt2En[i];
        assign oe2[i]    = alt2Oe[i];
        assign out2[i]   = alt2Out[i];
        assign dirEff[i] = portDir[i];
      end

      // fixed priority, third alternate on top
      assign own3[i]    = alt3En[i];
      assign own2[i]    = en2[i] & ~own3[i];
      assign own1[i]    = alt1En[i] & ~en2[i] & ~own3[i];
      assign ownPort[i] = ~alt1En[i] & ~en2[i] & ~own3[i];

      assign next_oe[i]  = own3[i] ? alt3Oe[i]
                         : own2[i] ? oe2[i]
                         : own1[i] ? alt1Oe[i]
                         : dirEff[i];
      assign next_out[i] = own3[i] ? alt3Out[i]
                         : own2[i] ? out2[i]
                         : own1[i] ? alt1Out[i]
                         : portOutReg[i];

      // pullup only on inputs, forced for reset and debug use
      if (i == RESET_PIN_IDX) begin : g_pr
        assign next_pull[i] = (~next_oe[i] & pullupEn[i])
                            | reset_pin_enable;
      end else if (i == DEBUG_PIN_IDX) begin : g_pd
        assign next_pull[i] = ~next_oe[i] & (pullupEn[i] | own2[i]);
      end else begin : g_pg
        assign next_pull[i] = ~next_oe[i] & pullupEn[i];
      end

      assign next_drive[i] = next_oe[i] & driveHigh[i];
      // debug use keeps the drive strength choice but has no slew control
      if (i == DEBUG_PIN_IDX) begin : g_sd
        assign next_slew[i] = next_oe[i] & slewEn[i] & ~own2[i];
      end else begin : g_sg
        assign next_slew[i] = next_oe[i] & slewEn[i];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // registered pad and routing outputs
  // ------------------------------------------------------------
  // one flop stage: a changed enable shows at the next clock, and
  // during reset every pad is a tristate input without pullup
  always_ff @(posedge clk) begin
    if (rst) begin
      pinOe        <= '0;
      pinOut       <= '0;
      pinPullup    <= '0;
      pinDriveHigh <= '0;
      pinSlew      <= '0;
      portIn       <= '0;
      alt1In       <= '0;
      alt2In       <= '0;
      alt3In       <= '0;
      pinState     <= '0;
    end else begin
      pinOe        <= next_oe;
      pinOut       <= next_out;
      pinPullup    <= next_pull;
      pinDriveHigh <= next_drive;
      pinSlew      <= next_slew;
      // only the owning function sees the pin level
      portIn       <= pinIn & ownPort;
      alt1In       <= pinIn & own1;
      alt2In       <= pinIn & own2;
      alt3In       <= pinIn & own3;
      pinState     <= pinIn;
    end
  end

endmodule // pin_function_mux

// ---- pin_mux_checker.sv ----
// port assertions for the pin function multiplexer
`timescale 1ns/10ps
module pin_mux_checker #(parameter int N = 26) (
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         read,
  input wire logic         write,
  input wire logic         waitrequest,
  input wire logic [N-1:0] pinIn,
  input wire logic [N-1:0] pinOut,
  input wire logic [N-1:0] pinOe,
  input wire logic [N-1:0] pinPullup,
  input wire logic         dbgBusy,
  input wire logic         dbgTxStart,
  input wire logic         resetRequest,
  input wire logic         activeBackgroundMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_answer; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("bus request not answered");
  property p_pulse; !waitrequest |=> waitrequest; endproperty
  a_pulse: assert property (p_pulse) else $error("waitrequest low too long");
  property p_idle; $fell(rst) |-> pinOe == '0 && pinPullup[N-1:2] == '0; endproperty
  a_idle: assert property (p_idle) else $error("pins not idle after reset");
  property p_rreq; resetRequest |-> $past(pinIn[0]) == 1'b0; endproperty
  a_rreq: assert property (p_rreq) else $error("reset request without low pin");
  property p_rpull; resetRequest |-> pinPullup[0]; endproperty
  a_rpull: assert property (p_rpull) else $error("reset pin pullup off");
  property p_mode; $fell(rst) |=> activeBackgroundMode == !$past(pinIn[1], 2); endproperty
  a_mode: assert property (p_mode) else $error("mode select wrong");
  property p_bit; $rose(dbgBusy) && $past(dbgTxStart, 2) |-> dbgBusy[*8] ##1 dbgBusy[*8] ##1 !dbgBusy; endproperty
  a_bit: assert property (p_bit) else $error("debug bit length wrong");
  property p_rxbit; $rose(dbgBusy) && !$past(dbgTxStart, 2) |-> dbgBusy[*8] ##1 dbgBusy[*7] ##1 !dbgBusy;
  endproperty
  a_rxbit: assert property (p_rxbit) else $error("received bit length wrong");
  property p_speed; pinOe[1] && pinOut[1] && dbgBusy |=> !(pinOe[1] && pinOut[1]); endproperty
  a_speed: assert property (p_speed) else $error("speedup pulse too long");
endmodule // pin_mux_checker
bind pin_function_mux pin_mux_checker #(.N(N)) chk (.clk, .rst, .read, .write, .waitrequest, .pinIn,
  .pinOut, .pinOe, .pinPullup, .dbgBusy, .dbgTxStart, .resetRequest, .activeBackgroundMode);

// ---- pin_mux_pkg.sv ----
// constants, offsets and types shared by the pin function multiplexer
package pin_mux_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int NUM_PINS      = 26;  // all multiplexed pins
  localparam int RESET_PIN_IDX = 0;   // port_b_bit0_pin
  localparam int DEBUG_PIN_IDX = 1;   // port_b_bit1_pin
  localparam int SEG_FIRST     = 2;   // first of the segment_driver_pins
  localparam int SEG_COUNT     = 22;  // segment_driver_pins count
  localparam int ADDR_W        = 6;   // byte address width of the slave

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [5:0] OFF_PORT_OUT  = 6'h00;  // port output data
  localparam logic [5:0] OFF_PORT_DIR  = 6'h04;  // port direction, 1 = output
  localparam logic [5:0] OFF_PULLUP    = 6'h08;  // pullup enables
  localparam logic [5:0] OFF_DRIVE     = 6'h0C;  // 1 = high drive strength
  localparam logic [5:0] OFF_SLEW      = 6'h10;  // 1 = slew control on
  localparam logic [5:0] OFF_ALT1_EN   = 6'h14;  // first alternate enables
  localparam logic [5:0] OFF_ALT2_EN   = 6'h18;  // second alternate enables
  localparam logic [5:0] OFF_ALT3_EN   = 6'h1C;  // third alternate enables
  localparam logic [5:0] OFF_SYS_OPT   = 6'h20;  // system_option_reg
  localparam logic [5:0] OFF_PIN_STATE = 6'h24;  // pin levels, read only
  localparam logic [5:0] OFF_STATUS    = 6'h28;  // block status, read only

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int SYSOPT_RESET_PIN_BIT = 0;  // reset_pin_enable
  localparam int SYSOPT_DEBUG_PIN_BIT = 1;  // debug_pin_enable
  localparam int STAT_BGND_BIT        = 0;  // active background mode
  localparam int STAT_RSTREQ_BIT      = 1;  // external reset request
  localparam int STAT_DBG_BUSY_BIT    = 2;  // debug bit in progress
  localparam logic [31:0] REG_RESET       = 32'h0000_0000;
  localparam logic        RESET_PIN_RESET = 1'b0;
  localparam logic        DEBUG_PIN_RESET = 1'b1;

  // ------------------------------------------------------------
  // debug wire bit timing, in debug clock cycles
  // ------------------------------------------------------------
  localparam int DBG_BIT_CYCLES  = 16;  // one bit time
  localparam int DBG_SAMPLE_AT   = 10;  // receive sample point
  localparam int DBG_LOW_ONE     = 4;   // low time of a one
  localparam int DBG_LOW_ZERO    = 13;  // low time of a zero
  localparam int DBG_SPEEDUP     = 1;   // driven-high speedup pulse

  // phy states
  typedef enum logic [2:0] {
    PHY_IDLE = 3'b001,
    PHY_RX   = 3'b010,
    PHY_TX   = 3'b100
  } phy_state_t;

endpackage

// ---- tb.sv ----
// self-checking bench for the pin function multiplexer
`timescale 1ns/10ps
module tb;
  import pin_mux_pkg::*;
  logic clk = 0, rst = 1, read = 0, write = 0, dbgTxStart = 0, dbgTxBit = 0;
  logic [5:0] address = '0;
  logic [31:0] writedata = '0, readdata, rd;
  logic [3:0] byteenable = 4'hF;
  logic waitrequest, dbgBusy, dbgRxBit, resetRequest, activeBackgroundMode;
  logic [25:0] pinIn, pinOut, pinOe, pinPullup, pinDriveHigh, pinSlew, extEn = '0, extVal = '0;
  logic [25:0] alt1Oe = '0, alt1Out = '0, alt2Oe = '0, alt2Out = '0, alt3Oe = '0, alt3Out = '0;
  int mismatches = 0, n_compared = 0, cyc = 0;
  pin_function_mux uut (.clk, .rst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .pinIn, .pinOut, .pinOe, .pinPullup, .pinDriveHigh, .pinSlew, .alt1Oe, .alt1Out, .alt2Oe, .alt2Out,
    .alt3Oe, .alt3Out, .portIn(), .alt1In(), .alt2In(), .alt3In(), .dbgTxStart, .dbgTxBit, .dbgBusy,
    .dbgRxValid(), .dbgRxBit, .resetRequest, .activeBackgroundMode);
  pad_partner pp (.clk, .pinOut, .pinOe, .pinPullup, .extEn, .extVal, .pinIn);
  always #4 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // one request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 0;
    read <= 0;
  endtask
  // host holds the mode pin at lvl across the reset release
  task automatic do_reset(input logic lvl);
    @(posedge clk);
    extEn[1] <= 1;
    extVal[1] <= lvl;
    rst <= 1;
    repeat (8) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    extEn[1] <= 0;
  endtask
  task automatic t_defaults;
    chk("oe", '0, pinOe);
    chk("pullup", 32'h2, pinPullup);
    bus(0, OFF_SYS_OPT, 0, rd); chk("sysopt", 32'h2, rd);
    bus(0, 6'h3C, 0, rd); chk("unmapped", 0, rd);
    $display("defaults done");
  endtask
  task automatic t_resetpin;
    bus(1, OFF_SYS_OPT, 32'h3, rd);
    bus(1, OFF_SYS_OPT, 32'h2, rd);
    bus(0, OFF_SYS_OPT, 0, rd); chk("sticky", 32'h3, rd);
    chk("pull0", 1, pinPullup[0]);
    extEn[0] <= 1;
    repeat (2) @(posedge clk); chk("rstreq", 1, resetRequest);
    extEn[0] <= 0;
    $display("reset pin done");
  endtask
  task automatic t_prio;
    bus(1, OFF_PORT_DIR, 32'h20, rd);
    bus(1, OFF_PORT_OUT, 32'h20, rd);
    bus(1, OFF_DRIVE, 32'h20, rd);
    bus(1, OFF_SLEW, 32'h20, rd);
    bus(1, OFF_PULLUP, 32'h40, rd);
    repeat (2) @(posedge clk); chk("port", 32'hF, {pinOe[5], pinOut[5], pinDriveHigh[5], pinSlew[5]});
    chk("pull6", 1, pinPullup[6]);
    alt2Oe[5] <= 1; alt2Out[5] <= 1; alt3Oe[5] <= 1;
    bus(1, OFF_ALT2_EN, 32'h20, rd);
    repeat (2) @(posedge clk); chk("alt2", 32'h3, {pinOe[5], pinOut[5]});
    bus(1, OFF_ALT3_EN, 32'h20, rd);
    repeat (2) @(posedge clk); chk("alt3", 32'h2, {pinOe[5], pinOut[5]});
    bus(1, OFF_ALT3_EN, 32'h0, rd);
    bus(1, OFF_ALT2_EN, 32'h0, rd);
    repeat (2) @(posedge clk); chk("port back", 32'h3, {pinOe[5], pinOut[5]});
    $display("priority done");
  endtask
  task automatic t_dbg;
    int hi, lo, bz;
    for (int b = 1; b >= 0; b--) begin
      dbgTxBit <= b[0];
      dbgTxStart <= 1;
      @(posedge clk) dbgTxStart <= 0;
      hi = 0; lo = 0; bz = 0;
      repeat (24) begin
        @(posedge clk);
        hi += ((pinOe[1] & pinOut[1]) === 1'b1);
        lo += ((pinOe[1] & !pinOut[1]) === 1'b1);
        bz += (dbgBusy === 1'b1);
      end
      chk("low", b ? 4 : 13, lo);
      chk("speedup", 1, hi);
      chk("busy", 16, bz);
    end
    $display("debug bits done");
  endtask
  task automatic t_mode;
    do_reset(0); chk("abm", 1, activeBackgroundMode);
    bus(0, OFF_STATUS, 0, rd); chk("status", 1, rd[0]);
    repeat (8) @(posedge clk); chk("rxbit", 1, dbgRxBit);
    do_reset(1); chk("normal", 0, activeBackgroundMode);
    bus(0, OFF_SYS_OPT, 0, rd); chk("cleared", 32'h2, rd);
    $display("mode select done");
  endtask
  initial begin
    do_reset(1);
    t_defaults;
    t_resetpin;
    t_prio;
    t_dbg;
    t_mode;
    conclude();
  end
endmodule // tb
